// ==== rtl/frc_top.sv ====
// three linked free-running counters with offset slaving of ch1 and ch2
// assumes controls arrive as plain ports synchronous to mclk; a control
// write is a one-cycle ctrl_wr pulse carrying stop and clear bits
//
// Behaviour
// - mode 0 without offset selects up-count
// - up-count runs zero to peak then wraps
// - up-count period is peak plus one
// - clear without stop zeroes and runs
// - clear with stop zeroes and halts
// - mode 1 without offset selects up/down
// - up/down climbs to peak, falls to zero
// - up/down period is twice the peak
// - clear during up/down restarts upward
// - ch1 offset enable slaves it to ch0
// - master clear loads zero and offsets, runs
// - slave counts offset to peak plus offset
// - offset up-count shares ch0 period
// - master clear with stop loads and halts
// - slaved channel ignores its own controls
// - ch2 offset behaves like ch1
// - offset up/down shares twice-peak period
// - clear in offset up/down restarts upward
// - report zero, peak, up, down state
// - zero and peak detect flags
`include "frc_regs.svh"
module frc_top
  import frc_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // count-clock divider ratio
  input wire logic [DIV_W-1:0] div_ratio,
  // per-channel control write: pulse with stop and clear bits
  input wire logic [`FRC_NUM_CH-1:0] ctrl_wr,
  input wire logic [`FRC_NUM_CH-1:0] ctrl_stop,
  input wire logic [`FRC_NUM_CH-1:0] counter_clear,
  input wire logic [`FRC_NUM_CH-1:0] mode,
  // offset mode selection
  input wire logic ch1_offset_enable,
  input wire logic ch2_offset_enable,
  // peak (or offset for slaved ch1/ch2) values
  input wire logic [`FRC_WIDTH-1:0] peak_or_offset_value0,
  input wire logic [`FRC_WIDTH-1:0] peak_or_offset_value1,
  input wire logic [`FRC_WIDTH-1:0] peak_or_offset_value2,
  // flag clears, one per channel
  input wire logic [`FRC_NUM_CH-1:0] zero_flag_clr,
  input wire logic [`FRC_NUM_CH-1:0] peak_flag_clr,
  // count values
  output logic [`FRC_WIDTH-1:0] current_count_value0,
  output logic [`FRC_WIDTH-1:0] current_count_value1,
  output logic [`FRC_WIDTH-1:0] current_count_value2,
  // count state for attached consumers
  output logic [`FRC_NUM_CH-1:0] state_zero,
  output logic [`FRC_NUM_CH-1:0] state_peak,
  output logic [`FRC_NUM_CH-1:0] state_up,
  output logic [`FRC_NUM_CH-1:0] state_down,
  output logic [`FRC_NUM_CH-1:0] running,
  // sticky detect flags
  output logic [`FRC_NUM_CH-1:0] zero_detect_flag,
  output logic [`FRC_NUM_CH-1:0] peak_detect_flag
);
  logic count_en; // shared count-clock enable
  logic [`FRC_NUM_CH-1:0] run; // own run bits
  logic [`FRC_NUM_CH-1:0] slaved; // channel follows ch0
  logic [`FRC_NUM_CH-1:0] clr_eff; // effective clear pulse
  logic [`FRC_NUM_CH-1:0] run_eff; // effective run
  logic [`FRC_NUM_CH-1:0] updown_eff; // effective mode
  logic [`FRC_WIDTH-1:0] rel [`FRC_NUM_CH];
  logic [`FRC_WIDTH-1:0] cnt [`FRC_NUM_CH];
  logic [`FRC_WIDTH-1:0] peak_eff [`FRC_NUM_CH];
  logic [`FRC_WIDTH-1:0] base_eff [`FRC_NUM_CH];
  count_dir_t dir [`FRC_NUM_CH];
  logic [`FRC_WIDTH-1:0] pov [`FRC_NUM_CH];
  logic [`FRC_NUM_CH-1:0] at_zero;
  logic [`FRC_NUM_CH-1:0] at_peak;
  logic [`FRC_NUM_CH-1:0] stepped;
  logic [`FRC_NUM_CH-1:0] stepped_q; // a step landed last cycle

  // a zero-width ratio has nothing to count; refuse it when elaborating
  if (DIV_W < 1)
  begin : g_bad_div_w
    $error("frc_top: DIV_W must be at least 1");
  end

  assign pov[0] = peak_or_offset_value0;
  assign pov[1] = peak_or_offset_value1;
  assign pov[2] = peak_or_offset_value2;
  assign slaved = {ch2_offset_enable, ch1_offset_enable, 1'b0};

  frc_divider #(.RATIO_W(DIV_W)) u_div
  (
    .mclk(mclk),
    .rst(rst),
    .div_ratio(div_ratio),
    .count_en(count_en)
  );

  // run bit per channel; a slaved channel's own writes are dropped
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      run <= '0;
    else
      for (int i = 0; i < `FRC_NUM_CH; i++)
        if (ctrl_wr[i] && !slaved[i])
          run[i] <= !ctrl_stop[i];
  end

  // resolve which control set drives each channel
  always_comb
  begin
    for (int i = 0; i < `FRC_NUM_CH; i++)
    begin
      if (slaved[i])
      begin
        clr_eff[i] = ctrl_wr[0] && counter_clear[0];
        run_eff[i] = run[0];
        updown_eff[i] = mode[0];
        peak_eff[i] = pov[0];
        base_eff[i] = pov[i];
      end
      else
      begin
        clr_eff[i] = ctrl_wr[i] && counter_clear[i];
        run_eff[i] = run[i];
        updown_eff[i] = mode[i];
        peak_eff[i] = pov[i];
        base_eff[i] = `FRC_ZERO;
      end
    end
  end

  // channel 0 is always a master; 1 and 2 follow it when slaved
  for (genvar g = 0; g < `FRC_NUM_CH; g++)
  begin : g_ch
    frc_channel u_ch
    (
      .mclk(mclk),
      .rst(rst),
      .count_en(count_en),
      .run(run_eff[g]),
      .clear_pulse(clr_eff[g]),
      .updown(updown_eff[g]),
      .peak(peak_eff[g]),
      .base(base_eff[g]),
      .slaved(slaved[g]),
      .master_rel(rel[0]),
      .master_dir(dir[0]),
      .master_step(count_en && run[0] && !clr_eff[0]),
      .rel(rel[g]),
      .count(cnt[g]),
      .dir(dir[g])
    );
    assign stepped[g] = count_en && run_eff[g] && !clr_eff[g];
  end

  // zero is the bottom of the relative count, peak is its top
  always_comb
  begin
    for (int i = 0; i < `FRC_NUM_CH; i++)
    begin
      at_zero[i] = (rel[i] == `FRC_ZERO);
      at_peak[i] = (rel[i] == peak_eff[i]);
    end
  end

  // registered outputs; values lag the internal count by one cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      current_count_value0 <= `FRC_ZERO;
      current_count_value1 <= `FRC_ZERO;
      current_count_value2 <= `FRC_ZERO;
      state_zero <= '0;
      state_peak <= '0;
      state_up <= '0;
      state_down <= '0;
      running <= '0;
    end
    else
    begin
      current_count_value0 <= cnt[0];
      current_count_value1 <= cnt[1];
      current_count_value2 <= cnt[2];
      state_zero <= at_zero;
      state_peak <= at_peak;
      running <= run_eff;
      for (int i = 0; i < `FRC_NUM_CH; i++)
      begin
        state_up[i] <= run_eff[i] && dir[i] == dir_up && !at_peak[i];
        state_down[i] <= run_eff[i] && dir[i] == dir_down;
      end
    end
  end

  // remember which channels landed on a new value
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stepped_q <= '0;
    else
      stepped_q <= stepped;
  end

  // sticky flags: a new detect wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      zero_detect_flag <= '0;
      peak_detect_flag <= '0;
    end
    else
      for (int i = 0; i < `FRC_NUM_CH; i++)
      begin
        if (stepped_q[i] && at_zero[i])
          zero_detect_flag[i] <= 1'b1;
        else if (zero_flag_clr[i])
          zero_detect_flag[i] <= 1'b0;
        if (stepped_q[i] && at_peak[i])
          peak_detect_flag[i] <= 1'b1;
        else if (peak_flag_clr[i])
          peak_detect_flag[i] <= 1'b0;
      end
  end

  // a clear write always lands the master on zero next cycle
  chk_clear_zeroes: assert property (@(posedge mclk) disable iff (rst)
    ctrl_wr[0] && counter_clear[0] |=> rel[0] == `FRC_ZERO)
    else $error("clear did not zero channel 0");

  // stop with clear halts the channel
  chk_stop_halts: assert property (@(posedge mclk) disable iff (rst)
    ctrl_wr[0] && counter_clear[0] && ctrl_stop[0] |=> !run[0] ##1 rel[0] == `FRC_ZERO)
    else $error("stop with clear did not halt channel 0");

  // up-count wraps from peak to zero
  chk_up_wrap: assert property (@(posedge mclk) disable iff (rst)
    stepped[0] && !mode[0] && rel[0] == pov[0] |=> rel[0] == `FRC_ZERO)
    else $error("up-count did not wrap at peak");

  // up-count increments by one below the peak
  chk_up_step: assert property (@(posedge mclk) disable iff (rst)
    stepped[0] && !mode[0] && rel[0] < pov[0] |=> rel[0] == $past(rel[0]) + `FRC_ONE)
    else $error("up-count did not step by one");

  // up/down turns at the peak
  chk_updown_turn: assert property (@(posedge mclk) disable iff (rst)
    stepped[0] && mode[0] && dir[0] == dir_up && rel[0] == pov[0] && rel[0] != `FRC_ZERO
    |=> dir[0] == dir_down)
    else $error("up/down did not turn at peak");

  // no step without the enable
  chk_hold_idle: assert property (@(posedge mclk) disable iff (rst)
    !count_en && !clr_eff[0] |=> $stable(rel[0]))
    else $error("channel 0 moved without count enable");

  // slaved channel 1 tracks master plus offset
  chk_slave_track: assert property (@(posedge mclk) disable iff (rst)
    ch1_offset_enable && $stable(ch1_offset_enable) |-> rel[1] == rel[0] || $past(rel[1]) != $past(rel[0]))
    else $error("slaved channel 1 lost step with channel 0");

  // own control write ignored when slaved
  chk_slave_ignore: assert property (@(posedge mclk) disable iff (rst)
    ch1_offset_enable && ctrl_wr[1] && !ctrl_wr[0] |=> $stable(run[1]))
    else $error("slaved channel 1 obeyed its own control");

  // clear restarts upward
  chk_clear_up: assert property (@(posedge mclk) disable iff (rst)
    ctrl_wr[0] && counter_clear[0] |=> dir[0] == dir_up)
    else $error("clear did not restart upward");

  // up/down leaves the bottom upward after the step from one
  chk_ud_bottom: assert property (@(posedge mclk) disable iff (rst)
    stepped[0] && mode[0] && dir[0] == dir_down && rel[0] == `FRC_ONE
    |=> rel[0] == `FRC_ZERO && dir[0] == dir_up)
    else $error("up/down did not turn at the bottom");

  // a master clear restarts slaved channel 1 at its offset
  chk_offset_load: assert property (@(posedge mclk) disable iff (rst)
    ch1_offset_enable && ctrl_wr[0] && counter_clear[0] |=> rel[1] == `FRC_ZERO)
    else $error("master clear did not load the channel 1 offset");

  // slaved channel 2 lands on the master's value at every edge
  chk_slave2_step: assert property (@(posedge mclk) disable iff (rst)
    ch2_offset_enable && rel[2] == rel[0] |=> rel[2] == rel[0])
    else $error("slaved channel 2 lost step with channel 0");

  // a zero landing sets the flag even against a clear
  chk_zero_wins: assert property (@(posedge mclk) disable iff (rst)
    stepped_q[0] && at_zero[0] |=> zero_detect_flag[0])
    else $error("zero detect flag lost to a clear");

  // a peak landing sets the flag even against a clear
  chk_peak_wins: assert property (@(posedge mclk) disable iff (rst)
    stepped_q[0] && at_peak[0] |=> peak_detect_flag[0])
    else $error("peak detect flag lost to a clear");
endmodule

// ==== rtl/frc_regs.svh ====
// constants for the linked free-running counter block
// assumes inclusion by bare name from the package and the modules
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH
`define FRC_WIDTH 16
`define FRC_ZERO 16'h0000
`define FRC_ONE 16'h0001
`define FRC_NUM_CH 3
`define FRC_MODE_UP 1'h0
`define FRC_MODE_UPDOWN 1'h1
`endif

// ==== rtl/frc_pkg.sv ====
// types shared by the linked free-running counter block
// assumes the constants header sits beside it in rtl/
`include "frc_regs.svh"
package frc_pkg;
  // counting direction of a channel
  typedef enum logic [0:0]
  {
    dir_up = 1'b0,
    dir_down = 1'b1
  } count_dir_t;
endpackage

// ==== rtl/frc_divider.sv ====
// count-clock enable divider: one-cycle pulse every div_ratio mclk cycles
// assumes mclk is the only clock and div_ratio is held stable while running
`include "frc_regs.svh"
module frc_divider
  import frc_pkg::*;
#(
  parameter int RATIO_W = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ratio, 0 and 1 both mean every cycle
  input wire logic [RATIO_W-1:0] div_ratio,
  // enable pulse
  output logic count_en
);
  // a zero-width ratio has nothing to count; refuse it when elaborating
  if (RATIO_W < 1)
  begin : g_bad_ratio_w
    $error("frc_divider: RATIO_W must be at least 1");
  end

  logic [RATIO_W-1:0] div_cnt; // cycles since the last pulse

  // counter wraps at ratio-1 and fires the pulse at the wrap
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt <= '0;
      count_en <= 1'b0;
    end
    else if (div_cnt + RATIO_W'(1) >= div_ratio)
    begin
      div_cnt <= '0;
      count_en <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + RATIO_W'(1);
      count_en <= 1'b0;
    end
  end
endmodule

// ==== rtl/frc_channel.sv ====
// one 16-bit counter channel: up or up/down, with an optional base offset
// assumes the caller resolves which control set (own or master) applies
`include "frc_regs.svh"
module frc_channel
  import frc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // effective controls
  input wire logic count_en,
  input wire logic run,
  input wire logic clear_pulse,
  input wire logic updown,
  input wire logic [`FRC_WIDTH-1:0] peak,
  input wire logic [`FRC_WIDTH-1:0] base,
  // master phase, used by slaved channels to stay in step
  input wire logic slaved,
  input wire logic [`FRC_WIDTH-1:0] master_rel,
  input wire logic master_dir,
  input wire logic master_step,
  // state outputs
  output logic [`FRC_WIDTH-1:0] rel,
  output logic [`FRC_WIDTH-1:0] count,
  output count_dir_t dir
);
  logic step; // one count step this cycle
  logic [`FRC_WIDTH-1:0] next_rel;
  count_dir_t next_dir;
  logic [`FRC_WIDTH:0] next_pair; // direction bit above the relative value

  // one step from a given state: wrap in up mode, reverse at the ends in up/down
  function automatic logic [`FRC_WIDTH:0] advance(input logic [`FRC_WIDTH-1:0] cur,
    input count_dir_t cur_dir, input logic ud, input logic [`FRC_WIDTH-1:0] top);
    logic [`FRC_WIDTH:0] res;
    res = {cur_dir, cur};
    if (!ud)
      res = {dir_up, (cur == top) ? `FRC_ZERO : cur + `FRC_ONE};
    else if (cur_dir == dir_up)
    begin
      if (cur >= top)
        res = {dir_down, cur - `FRC_ONE};
      else
        res = {dir_up, cur + `FRC_ONE};
    end
    else if (cur <= `FRC_ONE)
      res = {dir_up, `FRC_ZERO}; // bottom reached, turn around
    else
      res = {dir_down, cur - `FRC_ONE};
    return res;
  endfunction

  // a slave steps exactly when its master does
  assign step = slaved ? master_step : (count_en && run);

  // a slave advances from its master's state so both land together;
  // copying the master's present value would leave the slave a step behind
  always_comb
  begin
    if (slaved)
      next_pair = advance(master_rel, count_dir_t'(master_dir), updown, peak);
    else
      next_pair = advance(rel, dir, updown, peak);
    next_rel = next_pair[`FRC_WIDTH-1:0];
    next_dir = count_dir_t'(next_pair[`FRC_WIDTH]);
  end

  // relative count and direction; clear restarts upward from zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rel <= `FRC_ZERO;
      dir <= dir_up;
    end
    else if (clear_pulse)
    begin
      rel <= `FRC_ZERO;
      dir <= dir_up;
    end
    else if (step)
    begin
      rel <= next_rel;
      dir <= next_dir;
    end
  end

  // visible value adds the offset combinationally, so a new offset shows in the same cycle
  always_comb
  begin
    count = rel + base;
  end
endmodule

// ==== testbench/linked_free_running_counters_bench.sv ====
// self-checking bench for the three linked free-running counters
// assumes frc_top from rtl/, one clock, controls driven 1 ns after each edge
module linked_free_running_counters_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // clock and reset
  logic mclk = 1'b0;
  logic rst = 1'b1;
  // controls
  logic [7:0] div_ratio = 8'h01;
  logic [2:0] ctrl_wr = 3'h0;
  logic [2:0] ctrl_stop = 3'h0;
  logic [2:0] counter_clear = 3'h0;
  logic [2:0] mode = 3'h0;
  logic ch1_offset_enable = 1'b0;
  logic ch2_offset_enable = 1'b0;
  logic [15:0] peak_or_offset_value0 = 16'h0000;
  logic [15:0] peak_or_offset_value1 = 16'h0000;
  logic [15:0] peak_or_offset_value2 = 16'h0000;
  logic [2:0] zero_flag_clr = 3'h0;
  logic [2:0] peak_flag_clr = 3'h0;
  // observed state
  logic [15:0] current_count_value0, current_count_value1, current_count_value2;
  logic [2:0] state_zero, state_peak, state_up, state_down, running;
  logic [2:0] zero_detect_flag, peak_detect_flag;
  // bookkeeping
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int found;
  int i0;
  int last;
  logic [15:0] cap [3][64];

  frc_top i_dut (
    .mclk(mclk), .rst(rst), .div_ratio(div_ratio), .ctrl_wr(ctrl_wr),
    .ctrl_stop(ctrl_stop), .counter_clear(counter_clear), .mode(mode),
    .ch1_offset_enable(ch1_offset_enable), .ch2_offset_enable(ch2_offset_enable),
    .peak_or_offset_value0(peak_or_offset_value0),
    .peak_or_offset_value1(peak_or_offset_value1),
    .peak_or_offset_value2(peak_or_offset_value2),
    .zero_flag_clr(zero_flag_clr), .peak_flag_clr(peak_flag_clr),
    .current_count_value0(current_count_value0),
    .current_count_value1(current_count_value1),
    .current_count_value2(current_count_value2),
    .state_zero(state_zero), .state_peak(state_peak), .state_up(state_up),
    .state_down(state_down), .running(running),
    .zero_detect_flag(zero_detect_flag), .peak_detect_flag(peak_detect_flag)
  );

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one control write: the pulse is seen at exactly one rising edge
  task automatic wr(input logic [2:0] m, input logic [2:0] s, input logic [2:0] c);
    @(posedge mclk);
    #1;
    ctrl_wr = m;
    ctrl_stop = s;
    counter_clear = c;
    @(posedge mclk);
    #1;
    ctrl_wr = 3'h0;
  endtask

  // record n consecutive cycles of all three counts
  task automatic grab(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      #1;
      cap[0][i] = current_count_value0;
      cap[1][i] = current_count_value1;
      cap[2][i] = current_count_value2;
    end
  endtask

  // expected count t steps after a fresh start at base
  function automatic logic [15:0] expv(input bit md, input int pk, input int base, input int t);
    int p;
    p = md ? t % (2 * pk) : t % (pk + 1);
    if (md && p > pk)
      p = 2 * pk - p;
    return 16'(base + p);
  endfunction

  // find a fresh start within lead cycles, then follow it for 20 cycles
  task automatic seq(input int ch, input bit md, input int pk, input int base, input int lead);
    found = -1;
    for (int i = 0; i <= lead; i++)
      if (found < 0 && cap[ch][i] === 16'(base) && cap[ch][i+1] === 16'(base + 1))
        found = i;
    check("start found", 16'(found >= 0), 16'h0001);
    if (found >= 0)
      for (int j = 0; j < 20; j++)
        check("count", cap[ch][found+j], expv(md, pk, base, j));
  endtask

  // waits for ch0 or ch2 to reach a value, bounded
  task automatic wait_val(input int ch, input logic [15:0] v);
    for (int k = 0; k < 20; k++)
      if ((ch == 0 ? current_count_value0 : current_count_value2) !== v)
      begin
        @(posedge mclk);
        #1;
      end
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    // normal modes on all channels, started together
    mode = 3'h4;
    peak_or_offset_value0 = 16'h0005;
    peak_or_offset_value1 = 16'h0003;
    peak_or_offset_value2 = 16'h0004;
    wr(3'h7, 3'h0, 3'h7);
    grab(40);
    seq(0, 1'b0, 5, 0, 4);
    seq(1, 1'b0, 3, 0, 4);
    seq(2, 1'b1, 4, 0, 4);
    check("running", 16'(running), 16'h0007);
    check("zero flags", 16'(zero_detect_flag), 16'h0007);
    check("peak flags", 16'(peak_detect_flag), 16'h0007);
    $display("test normal modes done");
    // clear while descending must restart upward
    wait_val(2, 16'h0004);
    check("ch2 at peak", current_count_value2, 16'h0004);
    check("ch2 peak state", 16'(state_peak[2]), 16'h0001);
    wr(3'h4, 3'h0, 3'h4);
    grab(40);
    seq(2, 1'b1, 4, 0, 3);
    $display("test clear in up/down done");
    // stop with clear, then clear the sticky flags of the halted channel
    wr(3'h2, 3'h2, 3'h2);
    zero_flag_clr = 3'h2;
    peak_flag_clr = 3'h2;
    @(posedge mclk);
    #1;
    zero_flag_clr = 3'h0;
    peak_flag_clr = 3'h0;
    grab(8);
    check("halted count", cap[1][7], 16'h0000);
    check("halted still", cap[1][4], 16'h0000);
    check("halted run", 16'(running), 16'h0005);
    check("zero state", 16'(state_zero[1]), 16'h0001);
    check("flags cleared", 16'({zero_detect_flag[1], peak_detect_flag[1]}), 16'h0000);
    $display("test stop and clear done");
    // offset up-count, both slaves; a slave's own start write is ignored
    wr(3'h7, 3'h7, 3'h7);
    mode = 3'h6;
    ch1_offset_enable = 1'b1;
    ch2_offset_enable = 1'b1;
    peak_or_offset_value0 = 16'h0004;
    peak_or_offset_value1 = 16'h000A;
    peak_or_offset_value2 = 16'h0014;
    wr(3'h1, 3'h0, 3'h1);
    wr(3'h2, 3'h0, 3'h2);
    grab(40);
    seq(0, 1'b0, 4, 0, 8);
    i0 = found;
    seq(1, 1'b0, 4, 10, 8);
    check("ch1 in step", 16'(found), 16'(i0));
    seq(2, 1'b0, 4, 20, 8);
    check("ch2 in step", 16'(found), 16'(i0));
    check("slaves run", 16'(running), 16'h0007);
    $display("test offset up-count done");
    // master stop with clear loads bases and halts all
    wr(3'h1, 3'h1, 3'h1);
    grab(6);
    check("ch0 halted", cap[0][5], 16'h0000);
    check("ch1 halted", cap[1][5], 16'h000A);
    check("ch2 halted", cap[2][5], 16'h0014);
    check("none running", 16'(running), 16'h0000);
    check("bottom states", 16'(state_zero), 16'h0007);
    $display("test offset stop done");
    // offset up/down, then clear in mid-run
    mode = 3'h1;
    wr(3'h1, 3'h0, 3'h1);
    grab(40);
    seq(0, 1'b1, 4, 0, 4);
    i0 = found;
    seq(1, 1'b1, 4, 10, 4);
    check("ud in step", 16'(found), 16'(i0));
    wait_val(0, 16'h0004);
    check("top states", 16'(state_peak), 16'h0007);
    @(posedge mclk);
    #1;
    check("down states", 16'(state_down), 16'h0007);
    wr(3'h1, 3'h0, 3'h1);
    grab(40);
    seq(1, 1'b1, 4, 10, 3);
    seq(2, 1'b1, 4, 20, 3);
    $display("test offset up/down done");
    // slow count enable: steps are exactly three cycles apart
    wr(3'h1, 3'h1, 3'h1);
    ch1_offset_enable = 1'b0;
    ch2_offset_enable = 1'b0;
    mode = 3'h0;
    peak_or_offset_value0 = 16'h00FF;
    div_ratio = 8'h03;
    wr(3'h1, 3'h0, 3'h1);
    grab(40);
    last = -1;
    for (int i = 1; i < 40; i++)
      if (cap[0][i] !== cap[0][i-1])
      begin
        if (last >= 0)
          check("step gap", 16'(i - last), 16'h0003);
        last = i;
      end
    check("stepped", 16'(last > 20), 16'h0001);
    check("up state", 16'(state_up), 16'h0001);
    $display("test count enable done");
    test_done();
  end
endmodule
